// [logic/tps_defines.svh]
`ifndef TPS_DEFINES_SVH
`define TPS_DEFINES_SVH

// register offsets on the plain register port
`define TPS_ADDR_SYNC_CTRL 8'h00
`define TPS_ADDR_TMR0_SEL 8'h01
`define TPS_ADDR_TMR1_SEL 8'h02
`define TPS_ADDR_PRESC_LO 8'h03
`define TPS_ADDR_PRESC_HI 8'h04
`define TPS_ADDR_PIN_STAT 8'h05

// timer_sync_control field positions
`define TPS_BIT_SYNC_HOLD 7
`define TPS_BIT_PSC_RESET 0

// clock_source_select field
`define TPS_SEL_LSB 0
`define TPS_SEL_MSB 2

// reset values
`define TPS_RST_SYNC_CTRL 8'h00
`define TPS_RST_SEL 3'h0
`define TPS_RST_PRESC 10'h000

// prescaler width and the number of low bits behind each tap
`define TPS_PRESC_W 10
`define TPS_TAP_BITS_DIV8 3
`define TPS_TAP_BITS_DIV64 6
`define TPS_TAP_BITS_DIV256 8
`define TPS_TAP_BITS_DIV1024 10

// timing in system clock cycles (40 MHz, 25 ns period)
`define TPS_CLK_PERIOD_NS 25
`define TPS_EXT_DELAY_MIN_CYC 2
`define TPS_EXT_DELAY_MAX_CYC 3

`endif

// [logic/tps_pkg.sv]
package tps_pkg;

  // clock_source_select encoding for one timer
  typedef enum logic [2:0] {
    TPS_SEL_NONE = 3'h0,
    TPS_SEL_DIRECT = 3'h1,
    TPS_SEL_DIV8 = 3'h2,
    TPS_SEL_DIV64 = 3'h3,
    TPS_SEL_DIV256 = 3'h4,
    TPS_SEL_DIV1024 = 3'h5,
    TPS_SEL_EXT_FALL = 3'h6,
    TPS_SEL_EXT_RISE = 3'h7
  } tps_clk_sel_t;

  typedef logic [3:0] tps_taps_t;

endpackage

// [logic/tps_top.sv]
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "tps_defines.svh"

module tps_top
  import tps_pkg::*;
#(
  parameter int NUM_TIMERS = 2,
  parameter int ADDR_W = 8,
  parameter int DATA_W = 8
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [DATA_W-1:0] reg_rdata_out,
  input wire logic [NUM_TIMERS-1:0] ext_count_pin_in,
  output logic [NUM_TIMERS-1:0] timer_tick_out,
  output logic [3:0] prescaler_tap_out,
  output logic prescaler_reset_out
);

  // software state
  logic sync_hold_mode;
  logic prescaler_reset_bit;
  tps_clk_sel_t clock_source_select [NUM_TIMERS];

  // prescaler
  logic [`TPS_PRESC_W-1:0] presc_cnt;
  tps_taps_t tap_pulse;

  // pin synchronisers and edge detectors
  logic [NUM_TIMERS-1:0] pin_meta;
  logic [NUM_TIMERS-1:0] pin_sync;
  logic [NUM_TIMERS-1:0] pin_prev;
  logic [NUM_TIMERS-1:0] ext_count_pulse;

  logic wr_ctrl;
  logic [DATA_W-1:0] next_rdata;

  assign wr_ctrl = reg_wr_in && (reg_addr_in == ADDR_W'(`TPS_ADDR_SYNC_CTRL));

  // picks the tick for one timer from its select value
  function automatic logic sel_tick(input tps_clk_sel_t sel, input tps_taps_t taps,
                                    input logic rise, input logic fall);
    logic t;
    t = 1'b0;
    case (sel)
      TPS_SEL_NONE: t = 1'b0;
      TPS_SEL_DIRECT: t = 1'b1;
      TPS_SEL_DIV8: t = taps[0];
      TPS_SEL_DIV64: t = taps[1];
      TPS_SEL_DIV256: t = taps[2];
      TPS_SEL_DIV1024: t = taps[3];
      TPS_SEL_EXT_FALL: t = fall;
      TPS_SEL_EXT_RISE: t = rise;
      default: t = 1'b0;
    endcase
    return t;
  endfunction

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync_hold_mode <= 1'(`TPS_RST_SYNC_CTRL >> `TPS_BIT_SYNC_HOLD);
      prescaler_reset_bit <= 1'b0;
    end else if (wr_ctrl) begin
      sync_hold_mode <= reg_wdata_in[`TPS_BIT_SYNC_HOLD];
      prescaler_reset_bit <= reg_wdata_in[`TPS_BIT_PSC_RESET];
    end else if (!sync_hold_mode) begin
      // bit stays up only for the cycle it was written in
      prescaler_reset_bit <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        clock_source_select[i] <= tps_clk_sel_t'(`TPS_RST_SEL);
      end
    end else if (reg_wr_in) begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        if (reg_addr_in == ADDR_W'(`TPS_ADDR_TMR0_SEL + i)) begin
          clock_source_select[i] <= tps_clk_sel_t'(reg_wdata_in[`TPS_SEL_MSB:`TPS_SEL_LSB]);
        end
      end
    end
  end

  // free running, only the reset bit stops it
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      presc_cnt <= `TPS_RST_PRESC;
    end else if (prescaler_reset_bit) begin
      presc_cnt <= `TPS_RST_PRESC;
    end else begin
      presc_cnt <= presc_cnt + 1'b1;
    end
  end

  // each tap fires when its low bits are about to wrap
  localparam int TAP_BITS [4] = '{`TPS_TAP_BITS_DIV8, `TPS_TAP_BITS_DIV64,
                                  `TPS_TAP_BITS_DIV256, `TPS_TAP_BITS_DIV1024};
  generate
    for (genvar k = 0; k < 4; k++) begin : g_tap
      assign tap_pulse[k] = !prescaler_reset_bit && (&presc_cnt[TAP_BITS[k]-1:0]);
    end
  endgenerate

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prescaler_tap_out <= '0;
      prescaler_reset_out <= 1'b0;
    end else begin
      prescaler_tap_out <= tap_pulse;
      prescaler_reset_out <= prescaler_reset_bit;
    end
  end

  // two rising-edge stages stand in for latch plus register
  // the first stage feeds nothing but the second
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_meta <= '0;
      pin_sync <= '0;
      pin_prev <= '0;
    end else begin
      pin_meta <= ext_count_pin_in;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  assign ext_count_pulse = pin_sync ^ pin_prev;

  // registered tick adds the last cycle of latency
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      timer_tick_out <= '0;
    end else begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        timer_tick_out[i] <= sel_tick(clock_source_select[i], tap_pulse,
                                      ext_count_pulse[i] && pin_sync[i],
                                      ext_count_pulse[i] && !pin_sync[i]);
      end
    end
  end

  // read data exists only in the cycle after the strobe
  always_comb begin
    next_rdata = '0;
    if (reg_rd_in) begin
      case (reg_addr_in)
        ADDR_W'(`TPS_ADDR_SYNC_CTRL): begin
          next_rdata[`TPS_BIT_SYNC_HOLD] = sync_hold_mode;
          next_rdata[`TPS_BIT_PSC_RESET] = prescaler_reset_bit;
        end
        ADDR_W'(`TPS_ADDR_TMR0_SEL): next_rdata[`TPS_SEL_MSB:`TPS_SEL_LSB] = clock_source_select[0];
        ADDR_W'(`TPS_ADDR_TMR1_SEL): next_rdata[`TPS_SEL_MSB:`TPS_SEL_LSB] = clock_source_select[1];
        ADDR_W'(`TPS_ADDR_PRESC_LO): next_rdata = presc_cnt[7:0];
        ADDR_W'(`TPS_ADDR_PRESC_HI): next_rdata[1:0] = presc_cnt[`TPS_PRESC_W-1:8];
        ADDR_W'(`TPS_ADDR_PIN_STAT): next_rdata[NUM_TIMERS-1:0] = pin_sync;
        default: next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= '0;
    end else begin
      reg_rdata_out <= next_rdata;
    end
  end

  // checks

  AST_SEL_NONE_STOPS: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (clock_source_select[0] == TPS_SEL_NONE) |=> !timer_tick_out[0])
    else $error("timer 0 ticked with no source");

  AST_SEL_DIRECT_EVERY: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (clock_source_select[1] == TPS_SEL_DIRECT) [*2] |=> timer_tick_out[1] && $past(timer_tick_out[1]))
    else $error("direct select did not tick every cycle");

  // a prescaler reset restarts the phase, so it cancels the spacing check
  AST_DIV8_SPACING: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in || prescaler_reset_bit)
    (tap_pulse[0] && !prescaler_reset_bit) |=> !tap_pulse[0] [*7] ##1 (tap_pulse[0] || prescaler_reset_bit))
    else $error("divide by 8 tap spacing wrong");

  AST_TAP_NESTED: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    tap_pulse[3] |-> (tap_pulse[2] && tap_pulse[1] && tap_pulse[0] && presc_cnt == 10'h3FF))
    else $error("taps out of phase");

  AST_PRESC_RUNS: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    !prescaler_reset_bit |=> presc_cnt == $past(presc_cnt) + 10'h001)
    else $error("prescaler did not advance");

  AST_PRESC_CLEARED: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (prescaler_reset_bit && !wr_ctrl && !sync_hold_mode) |=> (presc_cnt == 10'h000) && !prescaler_reset_bit)
    else $error("reset bit did not clear prescaler and itself");

  AST_HOLD_KEEPS: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (sync_hold_mode && prescaler_reset_bit && !wr_ctrl) |=> prescaler_reset_bit && presc_cnt == 10'h000)
    else $error("hold mode lost the reset bit");

  AST_HOLD_RELEASE: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (wr_ctrl && !reg_wdata_in[`TPS_BIT_SYNC_HOLD]) ##1 !wr_ctrl |=> !prescaler_reset_bit)
    else $error("reset bit kept after hold release");

  AST_EXT_RISE_TICK: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    ($rose(pin_sync[0]) && clock_source_select[0] == TPS_SEL_EXT_RISE) |=> timer_tick_out[0])
    else $error("rising pin edge gave no tick");

  AST_EXT_LATENCY: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    ($fell(ext_count_pin_in[1]) && clock_source_select[1] == TPS_SEL_EXT_FALL) [*1] ##1
    (clock_source_select[1] == TPS_SEL_EXT_FALL && !ext_count_pin_in[1]) [*2] |=> timer_tick_out[1])
    else $error("falling pin edge not counted within three cycles");

  AST_EXT_NO_DIVIDE: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (clock_source_select[0] == TPS_SEL_EXT_RISE && !(ext_count_pulse[0] && pin_sync[0])) |=> !timer_tick_out[0])
    else $error("external tick without a pin edge");

  AST_READ_ONE_CYCLE: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    !reg_rd_in |=> reg_rdata_out == '0)
    else $error("read data outside its cycle");

  AST_SEL_DIV64_TICK: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (clock_source_select[0] == TPS_SEL_DIV64) |=> timer_tick_out[0] == $past(tap_pulse[1]))
    else $error("divide by 64 select does not follow its tap");

  AST_SEL_DIV256_TICK: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (clock_source_select[1] == TPS_SEL_DIV256) |=> timer_tick_out[1] == $past(tap_pulse[2]))
    else $error("divide by 256 select does not follow its tap");

  AST_SEL_DIV1024_TICK: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (clock_source_select[0] == TPS_SEL_DIV1024) |=> timer_tick_out[0] == $past(tap_pulse[3]))
    else $error("divide by 1024 select does not follow its tap");

  AST_SEL_DIV8_TICK: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (clock_source_select[1] == TPS_SEL_DIV8) |=> timer_tick_out[1] == $past(tap_pulse[0]))
    else $error("divide by 8 select does not follow its tap");

  AST_DIRECT_TIMER0: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (clock_source_select[0] == TPS_SEL_DIRECT) |=> timer_tick_out[0])
    else $error("direct select missed a tick");

  AST_TAP_OUT_COPY: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    1'b1 |=> prescaler_tap_out == $past(tap_pulse))
    else $error("tap output does not follow the taps");

  AST_RESET_OUT_COPY: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    1'b1 |=> prescaler_reset_out == $past(prescaler_reset_bit))
    else $error("reset output does not follow the reset bit");

  AST_TAPS_QUIET_IN_RESET: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    prescaler_reset_bit |-> tap_pulse == 4'h0)
    else $error("tap pulsed while prescaler held");

  AST_HOLD_COUNT_ZERO: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (sync_hold_mode && prescaler_reset_bit) |=> presc_cnt == 10'h000)
    else $error("prescaler moved while held");

  AST_PIN_TWO_STAGES: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    1'b1 |=> ##1 pin_sync == $past(ext_count_pin_in, 2))
    else $error("pin synchroniser depth wrong");

  AST_EXT_FALL_TICK: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    ($fell(pin_sync[1]) && clock_source_select[1] == TPS_SEL_EXT_FALL) |=> timer_tick_out[1])
    else $error("falling pin edge gave no tick");

  AST_EXT_ONE_PULSE: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    ($rose(pin_sync[0]) && clock_source_select[0] == TPS_SEL_EXT_RISE) ##1
    (clock_source_select[0] == TPS_SEL_EXT_RISE) |=> !timer_tick_out[0])
    else $error("one pin edge gave two ticks");

  AST_EXT_FALL_ONLY_EDGE: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (clock_source_select[1] == TPS_SEL_EXT_FALL && !(ext_count_pulse[1] && !pin_sync[1])) |=> !timer_tick_out[1])
    else $error("external tick without a falling edge");

  AST_HOLD_WRITE_ZERO: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (wr_ctrl && !reg_wdata_in[`TPS_BIT_SYNC_HOLD] && !reg_wdata_in[`TPS_BIT_PSC_RESET]) |=>
    !prescaler_reset_bit && !sync_hold_mode)
    else $error("write of zero left hold or reset set");

  AST_WRITE_ONE_RESETS: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (wr_ctrl && reg_wdata_in[`TPS_BIT_PSC_RESET]) |=> prescaler_reset_bit ##1 presc_cnt == 10'h000)
    else $error("writing the reset bit did not clear the prescaler");

  AST_SEL_WRITE: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (reg_wr_in && reg_addr_in == ADDR_W'(`TPS_ADDR_TMR1_SEL)) |=>
    clock_source_select[1] == tps_clk_sel_t'($past(reg_wdata_in[`TPS_SEL_MSB:`TPS_SEL_LSB])) &&
    clock_source_select[0] == $past(clock_source_select[0]))
    else $error("timer 1 select write wrong or leaked");

  AST_READ_SEL: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (reg_rd_in && reg_addr_in == ADDR_W'(`TPS_ADDR_TMR0_SEL)) |=>
    reg_rdata_out == DATA_W'($past(clock_source_select[0])))
    else $error("timer 0 select read back wrong");

  AST_READ_PIN: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (reg_rd_in && reg_addr_in == ADDR_W'(`TPS_ADDR_PIN_STAT)) |=> reg_rdata_out == DATA_W'($past(pin_sync)))
    else $error("pin status read back wrong");

endmodule

// [verification/tb_tps_top.sv]
`timescale 1ns/1ps
`include "tps_defines.svh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin bad_count++; \
  $display("ERROR %0t: got %0h want %0h", $time, a, e); end end

module tb_tps_top
  import tps_pkg::*;
;
  logic clk, rst_n, wr, rd, go;
  logic [7:0] addr, wdata, rdata, v;
  logic [1:0] pin, tick;
  logic [3:0] taps;
  logic prst;
  int bad_count, samples_checked, c0, c1, c2;
  int div[4] = '{8, 64, 256, 1024};

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  tps_top i_dut (.ref_clk_in(clk), .rst_n_in(rst_n), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .ext_count_pin_in(pin),
    .timer_tick_out(tick), .prescaler_tap_out(taps), .prescaler_reset_out(prst));

  tps_ext_src i_src (.clk_in(clk), .go_in(go), .pin_out(pin));

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // counts only clean highs so an unknown tick never scores
  task automatic run(input int n);
    c0 = 0;
    c1 = 0;
    c2 = 0;
    repeat (n) begin
      @(posedge clk);
      #1;
      c0 += int'(tick[0] === 1'b1);
      c1 += int'(tick[1] === 1'b1);
      c2 += int'(taps[0] === 1'b1);
    end
  endtask

  task automatic wrap_up;
    $display("checked %0d, errors %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    wrap_up();
  end

  initial begin
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    go = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    bad_count = 0;
    samples_checked = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(`TPS_ADDR_SYNC_CTRL, v);
    `CHK(v, `TPS_RST_SYNC_CTRL)
    rd_reg(`TPS_ADDR_TMR0_SEL, v);
    `CHK(v, 8'h00)
    wr_reg(8'h06, 8'hFF);
    rd_reg(8'h06, v);
    `CHK(v, 8'h00)
    run(20);
    `CHK(c0, 0)
    wr_reg(`TPS_ADDR_TMR1_SEL, {5'h00, TPS_SEL_DIRECT});
    wr_reg(`TPS_ADDR_SYNC_CTRL, 8'h01);
    rd_reg(`TPS_ADDR_SYNC_CTRL, v);
    `CHK(v, 8'h00)
    // two full periods hold exactly two ticks whatever the phase
    for (int s = 2; s < 6; s++) begin
      wr_reg(`TPS_ADDR_TMR0_SEL, 8'(s));
      run(2);
      run(2 * div[s-2]);
      `CHK(c0, 2)
      `CHK(c1, 2 * div[s-2])
    end
    wr_reg(`TPS_ADDR_TMR0_SEL, {5'h00, TPS_SEL_DIV8});
    wr_reg(`TPS_ADDR_SYNC_CTRL, 8'h81);
    rd_reg(`TPS_ADDR_SYNC_CTRL, v);
    `CHK(v, 8'h81)
    run(64);
    `CHK(c0, 0)
    `CHK(c1, 64)
    `CHK(c2, 0)
    `CHK(prst, 1'b1)
    rd_reg(`TPS_ADDR_PRESC_LO, v);
    `CHK(v, 8'h00)
    wr_reg(`TPS_ADDR_SYNC_CTRL, 8'h00);
    rd_reg(`TPS_ADDR_SYNC_CTRL, v);
    `CHK(v, 8'h00)
    run(64);
    `CHK(c0, 8)
    `CHK(c2, 8)
    wr_reg(`TPS_ADDR_TMR0_SEL, {5'h00, TPS_SEL_EXT_FALL});
    wr_reg(`TPS_ADDR_TMR1_SEL, {5'h00, TPS_SEL_EXT_RISE});
    run(2);
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    run(24);
    `CHK(c0, 4)
    `CHK(c1, 4)
    rd_reg(`TPS_ADDR_PIN_STAT, v);
    `CHK(v, 8'h00)
    wrap_up();
  end
endmodule

// [verification/tps_ext_src.sv]
`timescale 1ns/1ps

module tps_ext_src #(
  parameter int HALF = 2,
  parameter int PULSES = 4
) (
  input wire logic clk_in,
  input wire logic go_in,
  output logic [1:0] pin_out
);
  initial pin_out = 2'h0;

  // stable idle, slow edges
  // half period of two cycles keeps the source under the sampling limit
  always @(posedge clk_in) begin
    if (go_in) begin
      repeat (PULSES) begin
        repeat (HALF) @(posedge clk_in);
        pin_out <= 2'h3;
        repeat (HALF) @(posedge clk_in);
        pin_out <= 2'h0;
      end
    end
  end
endmodule
